// *** core/tbp_consts.svh ***
/*
 Constants of the timer based pulse generator: register indices,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from design files under core/.
*/
// Operation
// - Timer prescale ratios of 1, 4 and 16 from a 2-bit field
// - Unimplemented control and mode bits ignore writes, read zero
// - Reset loads period with ones, clears count, controls and flags
// - Duty byte registers are not reset and keep their contents
// - Period is (period+1) times four clocks times prescale ratio
// - After count equals period: clear count, set output unless duty is zero, latch duty
// - Duty is low byte as upper eight bits, mode bits 5:4 below
// - Output clears when duty equals count with two sub-tick bits
`ifndef TBP_CONSTS_SVH
`define TBP_CONSTS_SVH

// -----------------------------------------------------------------
// Register indices, byte address is four times the index
// -----------------------------------------------------------------
`define TBP_IDX_INTERRUPT_CONTROL    8'h0b
`define TBP_IDX_PERIPHERAL_FLAGS_1   8'h0c
`define TBP_IDX_TIMER2_COUNT         8'h11
`define TBP_IDX_TIMER2_CONTROL       8'h12
`define TBP_IDX_DUTY_LOW_BYTE        8'h15
`define TBP_IDX_DUTY_BUFFER_HIGH     8'h16
`define TBP_IDX_CAPTURE_PWM_CONTROL  8'h17
`define TBP_IDX_PORTC_DIRECTION      8'h87
`define TBP_IDX_PERIPHERAL_ENABLES_1 8'h8c
`define TBP_IDX_PERIOD_COMPARE       8'h92

// -----------------------------------------------------------------
// Fields
// -----------------------------------------------------------------
`define TBP_CTL_MASK        8'h7f
`define TBP_MODE_MASK       8'h3f
`define TBP_RUN_BIT         2
`define TBP_PWM_MODE        2'h3
`define TBP_PERIOD_FLAG_BIT 1
`define TBP_PIN_DIR_BIT     2

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define TBP_RST_ZERO        8'h00
`define TBP_RST_PERIOD      8'hff
`define TBP_RST_DIRECTION   8'hff

// -----------------------------------------------------------------
// Timing: one timer tick is four clocks times the prescale ratio
// -----------------------------------------------------------------
`define TBP_LIMIT_DIV1      6'h03
`define TBP_LIMIT_DIV4      6'h0f
`define TBP_LIMIT_DIV16     6'h3f

`endif

// *** core/tbp_pkg.sv ***
/*
 Types shared by the pulse generator modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tbp_pkg;
    typedef logic [7:0] tbp_byte_t;
    typedef enum logic [1:0] {
        TBP_PS_DIV1   = 2'h0,
        TBP_PS_DIV4   = 2'h1,
        TBP_PS_DIV16  = 2'h2,
        TBP_PS_DIV16B = 2'h3
    } tbp_ps_e;
endpackage

// *** core/tbp_core_if.sv ***
/*
 Signals between the controller, the prescaler and the output stage.
 Assumes all three parties run on one clock.
*/
`timescale 1ns/1ns
interface tbp_core_if;
    logic       run;
    logic [1:0] ps;
    logic       clr;
    logic       inc;
    logic [1:0] fine;
    logic       pwm_en;
    logic       period_end;
    logic [7:0] tmr;
    logic [9:0] duty_sh;
    logic       duty_nz;
    logic       pwm_out;

    modport presc (input run, ps, clr, output inc, fine);
    modport cmp   (input pwm_en, period_end, tmr, fine, duty_sh,
                   duty_nz, output pwm_out);
    modport ctl   (output run, ps, clr, pwm_en, period_end, tmr,
                   duty_sh, duty_nz, input inc, fine, pwm_out);
endinterface

// *** core/tbp_prescaler.sv ***
/*
 Prescaler: divides the clock into timer ticks and gives the two
 sub-tick bits used by the duty compare.
 Assumes controls come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "tbp_consts.svh"
module tbp_prescaler
    import tbp_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  reset_n,
    tbp_core_if.presc  bus
);
    typedef struct packed {
        logic [5:0] cnt;
    } tbp_presc_s;

    tbp_presc_s q_q;
    tbp_presc_s q_d;
    logic [5:0] limit;

    always_comb begin
        unique case (tbp_ps_e'(bus.ps))
            TBP_PS_DIV1: limit = `TBP_LIMIT_DIV1;
            TBP_PS_DIV4: limit = `TBP_LIMIT_DIV4;
            default:     limit = `TBP_LIMIT_DIV16;
        endcase
    end

    // Counter held, not cleared, while stopped
    always_comb begin
        q_d = q_q;
        if (bus.clr) begin
            q_d.cnt = 6'h00;
        end else if (bus.run) begin
            q_d.cnt = (q_q.cnt >= limit) ? 6'h00 : q_q.cnt + 6'h01;
        end
    end

    assign bus.inc = bus.run && !bus.clr && (q_q.cnt >= limit);

    always_comb begin
        unique case (tbp_ps_e'(bus.ps))
            TBP_PS_DIV1: bus.fine = q_q.cnt[1:0];
            TBP_PS_DIV4: bus.fine = q_q.cnt[3:2];
            default:     bus.fine = q_q.cnt[5:4];
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end
endmodule

// *** core/tbp_pwm_cmp.sv ***
/*
 Output stage: sets the pulse at each period start with nonzero duty
 and clears it on duty match.
 Assumes period_end and the buffered duty come from the controller.
*/
`timescale 1ns/1ns
`include "tbp_consts.svh"
module tbp_pwm_cmp
    import tbp_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  reset_n,
    tbp_core_if.cmp    bus
);
    typedef struct packed {
        logic out;
    } tbp_cmp_s;

    tbp_cmp_s q_q;
    tbp_cmp_s q_d;

    always_comb begin
        q_d = q_q;
        if (!bus.pwm_en) begin
            q_d.out = 1'b0;
        end else if (bus.period_end) begin
            q_d.out = bus.duty_nz;
        end else if ({bus.tmr, bus.fine} == bus.duty_sh) begin
            // Duty above period never matches, so output stays high
            q_d.out = 1'b0;
        end
    end

    // Low from the first clock of a match, not one clock later
    assign bus.pwm_out = q_q.out
                      && ({bus.tmr, bus.fine} != bus.duty_sh);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end
endmodule

// *** core/tbp_pwm_top.sv ***
/*
 Timer based pulse generator with APB register access, period timer,
 double-buffered 10-bit duty and interrupt flags.
 Assumes an APB master on sys_clk and a port data bit on the same
 clock that drives the pin when the pulse mode is off.
*/
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`include "tbp_consts.svh"
module tbp_pwm_top
    import tbp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        port_latch_bit,
    output logic             pulse_output_pin,
    output logic             pulse_output_oe_n,
    output logic             irq
);
    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        tbp_byte_t  intr_ctl;
        tbp_byte_t  flags;
        tbp_byte_t  enables;
        tbp_byte_t  period_timer_count;
        tbp_byte_t  period_timer_control;
        tbp_byte_t  mode_control_register;
        tbp_byte_t  port_direction_register;
        tbp_byte_t  period_register;
        logic [3:0] post_cnt;
        tbp_byte_t  rdata;
        logic       slverr;
        logic       pin;
        logic       oe_n;
    } tbp_top_s;

    // Duty bytes sit outside reset so they survive warm resets
    typedef struct packed {
        tbp_byte_t  duty_msb_register;
        tbp_byte_t  duty_shadow_register;
        logic [1:0] lsb_latch;
    } tbp_duty_s;

    tbp_top_s  q_q;
    tbp_top_s  q_d;
    tbp_duty_s dty_q;
    tbp_duty_s dty_d;

    tbp_core_if core ();

    logic       setup;
    logic       wr;
    logic [7:0] idx;
    logic       mapped;
    tbp_byte_t  rd;
    tbp_byte_t  wb;
    logic       pwm_on;
    logic       running;
    logic       match;
    logic       period_end;
    logic [9:0] duty_new;
    logic       flag_evt;

    // -------------------------------------------------------------
    // Submodules
    // -------------------------------------------------------------
    tbp_prescaler u_presc (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .bus     (core.presc)
    );

    tbp_pwm_cmp u_cmp (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .bus     (core.cmp)
    );

    // -------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------
    assign setup  = psel && !penable;
    assign wr     = psel && penable && pwrite;
    assign idx    = paddr[9:2];
    assign wb     = pwdata[7:0];
    assign pwm_on = q_q.mode_control_register[3:2] == `TBP_PWM_MODE;
    assign running = q_q.period_timer_control[`TBP_RUN_BIT];
    assign match  = q_q.period_timer_count == q_q.period_register;
    assign period_end = core.inc && match;
    assign flag_evt   = period_end
                     && (q_q.post_cnt == q_q.period_timer_control[6:3]);
    assign duty_new = {dty_q.duty_msb_register,
                       q_q.mode_control_register[5:4]};

    always_comb begin
        mapped = 1'b1;
        unique case (idx)
            `TBP_IDX_INTERRUPT_CONTROL:    rd = q_q.intr_ctl;
            `TBP_IDX_PERIPHERAL_FLAGS_1:   rd = q_q.flags;
            `TBP_IDX_TIMER2_COUNT:         rd = q_q.period_timer_count;
            `TBP_IDX_TIMER2_CONTROL:       rd = q_q.period_timer_control;
            `TBP_IDX_DUTY_LOW_BYTE:        rd = dty_q.duty_msb_register;
            `TBP_IDX_DUTY_BUFFER_HIGH:     rd = dty_q.duty_shadow_register;
            `TBP_IDX_CAPTURE_PWM_CONTROL:  rd = q_q.mode_control_register;
            `TBP_IDX_PORTC_DIRECTION:      rd = q_q.port_direction_register;
            `TBP_IDX_PERIPHERAL_ENABLES_1: rd = q_q.enables;
            `TBP_IDX_PERIOD_COMPARE:       rd = q_q.period_register;
            default: begin
                rd     = `TBP_RST_ZERO;
                mapped = 1'b0;
            end
        endcase
    end

    // -------------------------------------------------------------
    // Register and timer next state
    // -------------------------------------------------------------
    always_comb begin
        q_d = q_q;

        // Read data and error captured in setup, shown in access
        if (setup) begin
            q_d.rdata  = rd;
            q_d.slverr = !mapped;
        end

        // Timer advance, wraps on the tick after a period match
        if (core.inc) begin
            if (match) begin
                q_d.period_timer_count = `TBP_RST_ZERO;
                q_d.post_cnt = q_q.post_cnt + 4'h1;
                if (q_q.post_cnt == q_q.period_timer_control[6:3]) begin
                    // Postscaler only paces the flag, never the period
                    q_d.post_cnt = 4'h0;
                    q_d.flags[`TBP_PERIOD_FLAG_BIT] = 1'b1;
                end
            end else begin
                q_d.period_timer_count = q_q.period_timer_count + 8'h01;
            end
        end

        if (wr && mapped) begin
            unique case (idx)
                `TBP_IDX_INTERRUPT_CONTROL:
                    q_d.intr_ctl = wb;
                // Write one to clear; a same-cycle event still sets
                `TBP_IDX_PERIPHERAL_FLAGS_1:
                    q_d.flags = q_q.flags & ~wb;
                `TBP_IDX_TIMER2_COUNT: begin
                    q_d.period_timer_count = wb;
                end
                `TBP_IDX_TIMER2_CONTROL: begin
                    q_d.period_timer_control = wb & `TBP_CTL_MASK;
                end
                `TBP_IDX_CAPTURE_PWM_CONTROL: begin
                    q_d.mode_control_register = wb & `TBP_MODE_MASK;
                end
                `TBP_IDX_PORTC_DIRECTION:
                    q_d.port_direction_register = wb;
                `TBP_IDX_PERIPHERAL_ENABLES_1:
                    q_d.enables = wb;
                `TBP_IDX_PERIOD_COMPARE:
                    q_d.period_register = wb;
                default: begin
                    q_d.intr_ctl = q_q.intr_ctl;
                end
            endcase
        end

        // Set wins over a same-cycle write-one-to-clear
        if (flag_evt) begin
            q_d.flags[`TBP_PERIOD_FLAG_BIT] = 1'b1;
        end

        // Pin from flops; port bit drives it outside pulse mode
        q_d.pin  = pwm_on ? core.pwm_out : port_latch_bit;
        q_d.oe_n = q_q.port_direction_register[`TBP_PIN_DIR_BIT];
    end

    // -------------------------------------------------------------
    // Duty registers next state
    // -------------------------------------------------------------
    always_comb begin
        dty_d = dty_q;
        if (wr && idx == `TBP_IDX_DUTY_LOW_BYTE) begin
            dty_d.duty_msb_register = wb;
        end
        // Buffer is read-only in pulse mode
        if (wr && idx == `TBP_IDX_DUTY_BUFFER_HIGH && !pwm_on) begin
            dty_d.duty_shadow_register = wb;
        end
        if (period_end) begin
            dty_d.duty_shadow_register = duty_new[9:2];
            dty_d.lsb_latch            = duty_new[1:0];
        end
    end

    // -------------------------------------------------------------
    // Links to prescaler and output stage
    // -------------------------------------------------------------
    assign core.run        = running;
    assign core.ps         = q_q.period_timer_control[1:0];
    assign core.clr        = wr && idx == `TBP_IDX_TIMER2_COUNT;
    assign core.pwm_en     = pwm_on;
    assign core.period_end = period_end;
    assign core.tmr        = q_q.period_timer_count;
    assign core.duty_sh    = {dty_q.duty_shadow_register,
                              dty_q.lsb_latch};
    assign core.duty_nz    = duty_new != 10'h000;

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign prdata            = {24'h000000, q_q.rdata};
    assign pready            = 1'b1;
    assign pslverr           = psel && penable && q_q.slverr;
    assign pulse_output_pin  = q_q.pin;
    assign pulse_output_oe_n = q_q.oe_n;
    assign irq               = |(q_q.flags & q_q.enables);

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q_q <= '0;
            q_q.period_register         <= `TBP_RST_PERIOD;
            q_q.port_direction_register <= `TBP_RST_DIRECTION;
            q_q.oe_n                    <= 1'b1;
        end else begin
            q_q <= q_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        dty_q <= dty_d;
    end
endmodule

// *** tb/tbp_pwm_props.sv ***
/* Checker of the pulse generator top: bus answers, unused bits,
   pin enable and levels in reset.
   Assumes a bind onto tbp_pwm_top, one clock, no other view. */
`timescale 1ns/1ns
module tbp_pwm_props (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        port_latch_bit,
    input wire logic        pulse_output_pin,
    input wire logic        pulse_output_oe_n,
    input wire logic        irq
);
    // ----
    // Decode and direction shadow
    // ----
    logic [7:0] idx;
    logic       acc;
    logic       hit;
    logic       dir_q;
    assign idx = paddr[9:2];
    assign acc = psel && penable;
    assign hit = idx inside {8'h0b, 8'h0c, 8'h11, 8'h12, 8'h15, 8'h16,
                             8'h17, 8'h87, 8'h8c, 8'h92};
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            dir_q <= 1'b1;
        else if (acc && pwrite && idx == 8'h87)
            dir_q <= pwdata[2];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ----
    // Properties
    // ----
    ready_always_a: assert property (pready)
        else $error("pready low");
    err_gated_a: assert property (pslverr |-> acc)
        else $error("pslverr outside access");
    upper_zero_a: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    bad_index_a: assert property (acc && !hit |->
        pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access answered wrongly");
    good_index_a: assert property (acc && hit |-> !pslverr)
        else $error("mapped access flagged");
    ctl_msb_a: assert property (
        acc && !pwrite && idx == 8'h12 |-> !prdata[7])
        else $error("timer control bit 7 read high");
    mode_msb_a: assert property (
        acc && !pwrite && idx == 8'h17 |-> prdata[7:6] == 2'h0)
        else $error("mode control bits 7:6 read high");
    pin_dir_a: assert property (
        pulse_output_oe_n == $past(dir_q))
        else $error("pin enable differs from direction bit");
    reset_idle_a: assert property (disable iff (1'b0)
        !reset_n |-> pulse_output_oe_n && !pulse_output_pin && !irq)
        else $error("outputs active in reset");
    cover property (acc && !hit);
    cover property ($rose(irq));
    cover property ($rose(pulse_output_pin));
endmodule

bind tbp_pwm_top tbp_pwm_props tbp_pwm_props_i (
    .sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .port_latch_bit, .pulse_output_pin,
    .pulse_output_oe_n, .irq);

// *** tb/testbench.sv ***
/* Self-checking bench of the pulse generator: registers over APB,
   pulse period and width, period flag interrupt, port pass-through.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ns
module testbench;
    logic        sys_clk, reset_n, psel, penable, pwrite;
    logic        port_latch_bit, err, prev;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [31:0] seed = 32'd60;
    logic [7:0]  prd;
    logic [7:0]  mdl [256];
    logic [7:0]  rst_regs [8] = '{8'h0b, 8'h0c, 8'h11, 8'h12,
                                   8'h17, 8'h87, 8'h8c, 8'h92};
    wire  [31:0] prdata;
    wire         pready, pslverr, pulse_output_pin;
    wire         pulse_output_oe_n, irq;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          per, ratio, dut, hi, rises, mn;

    tbp_pwm_top tbp_pwm_top_i (.sys_clk, .reset_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .port_latch_bit, .pulse_output_pin, .pulse_output_oe_n, .irq);

    always #5 sys_clk = ~sys_clk;
    // ----
    // Hang guard: longest pulse case is about 4k cycles
    // ----
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 80000) begin
            mismatches++;
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] ix,
                       input logic [7:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, ix, 2'h0};
        pwdata <= (rnd() & 32'hffffff00) | {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        // Ends on the first clock that sees pready high
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Model keeps stored bits; flags register is write-one-to-clear
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        apb(1'b1, ix, d);
        mdl[ix] = (ix == 8'h0c) ? mdl[ix] & ~d : d & (ix == 8'h12 ?
                  8'h7f : ix == 8'h17 ? 8'h3f : 8'hff);
    endtask

    task automatic rdc(input logic [7:0] ix);
        apb(1'b0, ix, 8'h00);
        chk(rd, {24'h0, mdl[ix]});
        chk(err, 1'b0);
    endtask

    // Duty bytes are left alone: they survive a reset
    task automatic do_reset();
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (mdl[i])
            if (i != 8'h15 && i != 8'h16)
                mdl[i] = 8'h00;
        mdl[8'h87] = 8'hff;
        mdl[8'h92] = 8'hff;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        port_latch_bit = 1'b0;
        // Falls once every flop waits, so its reset edge is seen
        reset_n <= 1'b0;
        do_reset();
        foreach (rst_regs[i])
            rdc(rst_regs[i]);
        wr(8'h12, 8'hff);
        rdc(8'h12);
        wr(8'h17, 8'hff);
        rdc(8'h17);
        wr(8'h17, 8'h00);
        wr(8'h12, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h20, 8'haa);
        apb(1'b0, 8'h20, 8'h00);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        wr(8'h87, 8'hfb);
        repeat (2) @(posedge sys_clk);
        chk(pulse_output_oe_n, 1'b0);
        repeat (4) begin
            prd = 8'(rnd());
            port_latch_bit <= prd[0];
            repeat (3) @(posedge sys_clk);
            chk(pulse_output_pin, prd[0]);
        end
        // ----
        // Pulse runs: every prescale code, zero and oversize duty
        // ----
        for (int k = 0; k < 6; k++) begin
            prd = 8'(rnd() % 8 + 3);
            ratio = (k % 4 == 0) ? 1 : (k % 4 == 1) ? 4 : 16;
            per = (prd + 1) * 4 * ratio;
            dut = (k == 4) ? 0 : (k == 5) ? 1023 : rnd() % ((prd + 1) * 4);
            wr(8'h12, 8'h00);
            wr(8'h11, 8'h00);
            wr(8'h92, prd);
            wr(8'h15, 8'(dut >> 2));
            wr(8'h17, {2'h0, 2'(dut), 4'h0});
            wr(8'h12, {6'h01, 2'(k % 4)});
            wr(8'h17, {2'h0, 2'(dut), 4'hc});
            repeat (3 * per) @(posedge sys_clk);
            hi = 0;
            rises = 0;
            prev = pulse_output_pin;
            repeat (2 * per) begin
                @(posedge sys_clk);
                hi += pulse_output_pin;
                rises += pulse_output_pin && !prev;
                prev = pulse_output_pin;
            end
            mn = (dut * ratio < per) ? dut * ratio : per;
            chk(hi, 2 * mn);
            chk(rises, (dut == 0 || dut * ratio >= per) ? 0 : 2);
            mdl[8'h16] = 8'(dut >> 2);
            rdc(8'h16);
        end
        wr(8'h8c, 8'h02);
        repeat (per + 8) @(posedge sys_clk);
        chk(irq, 1'b1);
        mdl[8'h0c] = 8'h02;
        rdc(8'h0c);
        wr(8'h8c, 8'h00);
        @(posedge sys_clk);
        chk(irq, 1'b0);
        wr(8'h12, 8'h00);
        wr(8'h0c, 8'h02);
        wr(8'h8c, 8'h02);
        @(posedge sys_clk);
        chk(irq, 1'b0);
        rdc(8'h0c);
        wr(8'h15, 8'h5a);
        do_reset();
        rdc(8'h15);
        rdc(8'h16);
        rdc(8'h92);
        end_sim();
    end
endmodule
